// >>> dv/src_far_end.sv
`timescale 1ns/10ps
module src_far_end
	import src_port_pkg::*;
(
	input  wire logic    clk_sys,
	input  wire logic    run,
	input  wire stereo_t tx_pair,
	input  wire logic [7:0] up_ratio,
	input  wire logic    sdo,
	output pclk_t        clk_o,
	output logic         data_o,
	output logic         chain_o,
	output logic [63:0]  rx_frame,
	output logic         rx_done
);
	logic [3:0]  div_q;
	logic [5:0]  bit_q;
	logic [5:0]  nb;
	logic [63:0] sh_q;
	logic [63:0] img;
	logic [63:0] cimg;
	// next slot and the left-justified image of the pair
	assign nb  = bit_q + 6'h1;
	assign img = {tx_pair.left, 8'h00, tx_pair.right, 8'h00};
	// upstream matched-phase master: pair with its ratio in the low byte
	assign cimg = {tx_pair.left, up_ratio, tx_pair.right, up_ratio};
	// bit clock of 16 clk_sys, low first; still while idle
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			div_q   <= 4'h0;
			bit_q   <= 6'h3f;
			clk_o   <= '0;
			rx_done <= 1'b0;
			data_o  <= (data_o !== 1'b1);
			chain_o <= (chain_o !== 1'b1);
		end else begin
			div_q   <= div_q + 4'h1;
			rx_done <= 1'b0;
			if (div_q == 4'h7) begin
				// rising edge: take the device's bit
				clk_o.bclk <= 1'b1;
				sh_q       <= {sh_q[62:0], sdo};
				rx_frame   <= (bit_q == 6'h3f) ? {sh_q[62:0], sdo} : rx_frame;
				rx_done    <= (bit_q == 6'h3f);
			end
			if (div_q == 4'hf) begin
				// falling edge: 32 slots per channel, left high
				clk_o.bclk  <= 1'b0;
				clk_o.lrclk <= !nb[5];
				bit_q       <= nb;
				data_o      <= (nb[4:0] < 5'h18) ? img[6'h3f - nb] : !data_o;
				chain_o     <= cimg[6'h3f - nb];
			end
		end
	end
endmodule

// >>> dv/src_serial_port_test.sv
`timescale 1ns/10ps
module src_serial_port_test
	import src_port_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [2:0]  input_format_select = 3'h0;
	logic [1:0]  output_format_select = 2'h0;
	logic [1:0]  output_width_select = 2'h0;
	logic [2:0]  port_clock_role_select = 3'h0;
	logic        bypass = 1'b0;
	logic        pack16 = 1'b0;
	logic        conv_valid = 1'b0;
	logic        run = 1'b0;
	logic        sel_in = 1'b0;
	logic [7:0]  own_ratio = 8'h5a;
	logic [7:0]  up_ratio = 8'h00;
	logic        mp_test = 1'b0;
	logic        chain_w;
	stereo_t     conv_pair = '0;
	stereo_t     tx_pair = '0;
	stereo_t     in_pair;
	pclk_t       in_clk_i, in_clk_o, in_clk_oe, out_clk_i, out_clk_o, out_clk_oe;
	pclk_t       far_clk, mclk;
	logic        in_data, tdm_in, serial_data_out, serial_data_out_oe;
	logic        conv_ready, in_pair_valid, rx_done;
	logic [7:0]  ratio_used;
	logic [63:0] rx_frame;
	int          failures = 0;
	int          cmp_count = 0;
	// clock
	always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	// pin level: whoever enables drives, else the far end
	assign in_clk_i  = (in_clk_o & in_clk_oe) | (far_clk & ~in_clk_oe);
	assign out_clk_i = (out_clk_o & out_clk_oe) | (far_clk & ~out_clk_oe);
	assign mclk      = sel_in ? in_clk_o : out_clk_o;
	// chain input grounded unless a matched-phase master feeds it
	assign tdm_in    = mp_test ? chain_w : 1'b0;
	src_serial_port dut_u (
		.clk_sys, .rstn, .input_format_select, .output_format_select,
		.output_width_select, .port_clock_role_select, .bypass, .pack16,
		.in_clk_i, .in_clk_o, .in_clk_oe, .in_data, .out_clk_i, .out_clk_o,
		.out_clk_oe, .tdm_in, .serial_data_out, .serial_data_out_oe,
		.conv_pair, .conv_valid, .conv_ready, .own_ratio, .in_pair,
		.in_pair_valid, .ratio_used
	);
	src_far_end far_u (
		.clk_sys, .run, .tx_pair, .up_ratio, .sdo(serial_data_out), .clk_o(far_clk),
		.data_o(in_data), .chain_o(chain_w), .rx_frame, .rx_done
	);
	// compare and count
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// wait for n input pairs or n captured frames
	task automatic wait_ev(input logic on_valid, input int n);
		int t;
		int lim;
		lim = 3000 * n;
		for (t = 0; t < lim && n > 0; t++) begin
			@(negedge clk_sys);
			if ((on_valid ? in_pair_valid : rx_done) === 1'b1) n--;
		end
		if (n > 0) check("event wait", 64'h0, 64'h1);
		@(posedge clk_sys);
	endtask
	// reset with new pin settings, checks pins around it
	task automatic do_reset(input logic [2:0] role, input logic [1:0] wsel, input logic byp,
			input logic [1:0] ofmt);
		run                    <= 1'b0;
		rstn                   <= 1'b0;
		port_clock_role_select <= role;
		output_format_select   <= ofmt;
		output_width_select    <= wsel;
		bypass                 <= byp;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		check("pins in reset", 64'h0, {in_clk_oe, out_clk_oe, serial_data_out_oe});
		@(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		check("data oe", 64'h1, serial_data_out_oe);
		@(posedge clk_sys);
	endtask
	// push one pair, holding valid until taken
	task automatic push(input stereo_t p);
		int t;
		logic ok;
		ok = 1'b0;
		conv_pair  <= p;
		conv_valid <= 1'b1;
		for (t = 0; t < 50 && !ok; t++) begin
			@(negedge clk_sys);
			ok = (conv_ready === 1'b1);
			@(posedge clk_sys);
		end
		conv_valid <= 1'b0;
		check("push taken", 64'h1, ok);
	endtask
	// clk_sys cycles between two rises of a generated clock bit
	task automatic period(input int b, output int per);
		int t;
		int first;
		logic [1:0] last;
		first = -1;
		per   = 0;
		last  = mclk;
		for (t = 0; t < 2000 && per == 0; t++) begin
			@(negedge clk_sys);
			if (mclk[b] === 1'b1 && last[b] === 1'b0) begin
				if (first >= 0) per = t - first;
				if (first < 0) first = t;
			end
			last = mclk;
		end
		@(posedge clk_sys);
	endtask
	// every master role: startup delay, single master, divider ratios
	task automatic master_clocks();
		int r;
		int bp;
		int fp;
		for (r = 1; r < 8; r++) begin
			if (r != 4) begin
				do_reset(r[2:0], 2'h0, 1'b0, {r[0], 1'b0});
				sel_in = r[2];
				repeat (1012) @(posedge clk_sys);
				@(negedge clk_sys);
				check("clock oe early", 64'h0, {in_clk_oe, out_clk_oe});
				repeat (20) @(posedge clk_sys);
				@(negedge clk_sys);
				check("clock oe", r[2] ? 64'hc : 64'h3, {in_clk_oe, out_clk_oe});
				period(1, bp);
				check("bit period", 4 * (4 - r[1:0]), bp);
				period(0, fp);
				check("frame period", 256 * (4 - r[1:0]), fp);
			end
		end
		$display("test master_clocks done");
	endtask
	// slave ports: input pair, buffer full, output frames
	task automatic slave_frames();
		stereo_t a;
		stereo_t b;
		stereo_t c;
		a = {24'h80_0001, 24'h7f_fffe};
		b = {24'h12_3456, 24'h65_4321};
		c = {24'h00_00ff, 24'hff_ff00};
		do_reset(3'h0, 2'h0, 1'b0, 2'h0);
		tx_pair <= a;
		run     <= 1'b1;
		wait_ev(1'b1, 2);
		check("input pair", a, in_pair);
		wait_ev(1'b0, 1);
		repeat (20) @(posedge clk_sys);
		push(b);
		@(posedge clk_sys);
		push(c);
		@(negedge clk_sys);
		check("buffer full", 64'h0, conv_ready);
		@(posedge clk_sys);
		wait_ev(1'b0, 2);
		check("frame b", {b.left, own_ratio, b.right, own_ratio}, rx_frame);
		check("ratio used", own_ratio, ratio_used);
		wait_ev(1'b0, 1);
		check("frame c", {c.left, own_ratio, c.right, own_ratio}, rx_frame);
		wait_ev(1'b0, 1);
		check("frame repeat", {c.left, own_ratio, c.right, own_ratio}, rx_frame);
		$display("test slave_frames done");
	endtask
	// bypass at 16-bit width: no conversion, no dither
	task automatic bypass_path();
		stereo_t d;
		d = {24'h12_34ff, 24'hab_cdff};
		do_reset(3'h0, 2'h3, 1'b1, 2'h0);
		tx_pair <= d;
		run     <= 1'b1;
		@(negedge clk_sys);
		check("bypass refuses", 64'h0, conv_ready);
		@(posedge clk_sys);
		wait_ev(1'b1, 2);
		wait_ev(1'b0, 2);
		check("bypass left", d.left[23:8], rx_frame[63:48]);
		check("bypass right", d.right[23:8], rx_frame[31:16]);
		$display("test bypass_path done");
	endtask
	// matched-phase slave in TDM: ratio from the chain replaces its own
	task automatic chain_ratio();
		stereo_t e;
		e = {24'h5a_a5c3, 24'h3c_0ff0};
		do_reset(3'h4, 2'h0, 1'b0, 2'h2);
		mp_test  <= 1'b1;
		up_ratio <= 8'hc3;
		tx_pair  <= e;
		run      <= 1'b1;
		push(e);
		wait_ev(1'b0, 4);
		check("chain ratio", 64'hc3, ratio_used);
		check("slave frame", {e.left, 8'hc3, e.right, 8'hc3}, rx_frame);
		mp_test <= 1'b0;
		$display("test chain_ratio done");
	endtask
	// verdict and end of run
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// scenario sequence
	initial begin
		@(posedge clk_sys);
		master_clocks();
		slave_frames();
		bypass_path();
		chain_ratio();
		close_out();
	end
	// hang guard, well above the expected run length
	initial begin
		repeat (80000) @(posedge clk_sys);
		failures++;
		$display("[FAIL] run length expected finish seen timeout");
		close_out();
	end
endmodule

// >>> verilog/pair_fifo.sv
`timescale 1ns/10ps
module pair_fifo
	import src_port_pkg::*;
(
	input  wire logic    clk_sys,
	input  wire logic    rstn,
	input  wire logic    in_valid,
	output logic         in_ready,
	input  wire stereo_t in_data,
	output logic         out_valid,
	input  wire logic    out_ready,
	output stereo_t      out_data
);
	stereo_t    mem_q [2];
	logic       wr_q;
	logic       rd_q;
	logic [1:0] cnt_q;
	logic       push;
	logic       pop;

	// two-entry ring, full and empty from the fill count
	assign in_ready  = (cnt_q != 2'd2);
	assign out_valid = (cnt_q != 2'd0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage write
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'd0;
		end else begin
			if (push)
				wr_q <= !wr_q;
			if (pop)
				rd_q <= !rd_q;
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		end
	end
endmodule

// >>> verilog/src_port_pkg.sv
package src_port_pkg;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SAMPLE_W       = 24;
	localparam int RATIO_W        = 8;
	localparam int FRAME_BITS     = 64;
	localparam int SUB_BITS       = 32;
	localparam int MCLK_768       = 768;
	localparam int MCLK_512       = 512;
	localparam int MCLK_256       = 256;
	localparam int BIT_DIV_768    = MCLK_768 / FRAME_BITS;
	localparam int BIT_DIV_512    = MCLK_512 / FRAME_BITS;
	localparam int BIT_DIV_256    = MCLK_256 / FRAME_BITS;
	localparam int STARTUP_CYCLES = 1024;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [2:0] IFMT_LJ  = 3'h0;
	localparam logic [2:0] IFMT_I2S = 3'h1;
	localparam logic [1:0] OFMT_I2S = 2'h1;
	localparam logic [1:0] OFMT_TDM = 2'h2;
	localparam logic [1:0] OFMT_RJ  = 2'h3;
	localparam logic [2:0] ROLE_MP  = 3'h4;
	localparam logic [4:0] W_16 = 5'd16;
	localparam logic [4:0] W_18 = 5'd18;
	localparam logic [4:0] W_20 = 5'd20;
	localparam logic [4:0] W_24 = 5'd24;

	typedef struct packed {
		logic [SAMPLE_W-1:0] left;
		logic [SAMPLE_W-1:0] right;
	} stereo_t;

	typedef struct packed {
		logic bclk;
		logic lrclk;
	} pclk_t;

	typedef struct packed {
		logic       in_m;
		logic       out_m;
		logic       mp_slave;
		logic [1:0] mult;
	} role_t;

	// role pins to port roles; encoding never yields two masters
	function automatic role_t decode_role(input logic [2:0] c);
		role_t r;
		r.out_m    = !c[2] && (c[1:0] != 2'h0);
		r.in_m     = c[2] && (c[1:0] != 2'h0);
		r.mp_slave = (c == ROLE_MP);
		r.mult     = c[1:0];
		return r;
	endfunction
endpackage

// >>> verilog/src_serial_port.sv
`timescale 1ns/10ps
module src_serial_port
	import src_port_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic [2:0]   input_format_select,
	input  wire logic [1:0]   output_format_select,
	input  wire logic [1:0]   output_width_select,
	input  wire logic [2:0]   port_clock_role_select,
	input  wire logic         bypass,
	input  wire logic         pack16,
	input  wire pclk_t        in_clk_i,
	output pclk_t             in_clk_o,
	output pclk_t             in_clk_oe,
	input  wire logic         in_data,
	input  wire pclk_t        out_clk_i,
	output pclk_t             out_clk_o,
	output pclk_t             out_clk_oe,
	input  wire logic         tdm_in,
	output logic              serial_data_out,
	output logic              serial_data_out_oe,
	input  wire stereo_t      conv_pair,
	input  wire logic         conv_valid,
	output logic              conv_ready,
	input  wire logic [7:0]   own_ratio,
	output stereo_t           in_pair,
	output logic              in_pair_valid,
	output logic [7:0]        ratio_used
);
	// width of output word from select pins
	function automatic logic [4:0] out_width(input logic [1:0] s);
		unique case (s)
			2'h0: return W_24;
			2'h1: return W_20;
			2'h2: return W_18;
			default: return W_16;
		endcase
	endfunction

	// dither into discarded bits, left undithered where the sum would wrap
	function automatic logic [23:0] shape(input logic [23:0] s, input logic [4:0] w,
			input logic [7:0] rnd, input logic dith);
		logic [23:0] keep;
		logic [24:0] sum;
		keep = ~(24'hff_ffff >> w);
		sum  = {s[23], s} + {17'h0_0000, rnd & ~keep[7:0]};
		if (!dith || (sum[24] != sum[23]))
			sum = {s[23], s};
		return sum[23:0] & keep;
	endfunction

	// one channel subframe, ratio low for LJ/I2S/TDM, high for RJ
	function automatic logic [31:0] subframe(input logic [23:0] s, input logic [7:0] r,
			input logic rj, input logic [4:0] w);
		logic [23:0] rs;
		rs = 24'($signed(s) >>> (5'd24 - w));
		return rj ? {r, rs} : {s, r};
	endfunction

	role_t       role;
	logic        ofmt_i2s;
	logic        ofmt_tdm;
	logic        ofmt_rj;
	logic        ifmt_i2s;
	logic        ifmt_rj;
	logic        m_i2s;
	logic        m_tdm;
	logic [4:0]  per;
	logic [5:0]  fmask;
	logic [4:0]  wout;
	logic        dither_on;

	assign role      = decode_role(port_clock_role_select);
	assign ofmt_i2s  = (output_format_select == OFMT_I2S);
	assign ofmt_tdm  = (output_format_select == OFMT_TDM);
	assign ofmt_rj   = (output_format_select == OFMT_RJ);
	assign ifmt_i2s  = (input_format_select == IFMT_I2S);
	assign ifmt_rj   = input_format_select[2];
	assign m_i2s     = role.in_m ? ifmt_i2s : ofmt_i2s;
	assign m_tdm     = role.out_m && ofmt_tdm;
	assign wout      = out_width(output_width_select);
	assign dither_on = !bypass && (wout != W_24);
	assign fmask     = pack16 ? 6'h1f : 6'h3f;

	// bit period in master clocks, doubled for 32-clock frames
	always_comb begin
		unique case (role.mult)
			2'h1: per = 5'(BIT_DIV_768);
			2'h2: per = 5'(BIT_DIV_512);
			default: per = 5'(BIT_DIV_256);
		endcase
		if (pack16)
			per = {per[3:0], 1'b0};
	end

	// pin synchronisers: in bclk, in lr, in data, out bclk, out lr, chain in
	logic [5:0] s1_q;
	logic [5:0] s2_q;
	logic [5:0] s3_q;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 6'h00;
			s2_q <= 6'h00;
			s3_q <= 6'h00;
		end else begin
			s1_q <= {in_clk_i.bclk, in_clk_i.lrclk, in_data,
				out_clk_i.bclk, out_clk_i.lrclk, tdm_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// startup delay before master clock pins drive
	logic [10:0] start_cnt_q;
	logic        clk_live_q;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			start_cnt_q <= 11'h000;
			clk_live_q  <= 1'b0;
		end else if (!clk_live_q) begin
			start_cnt_q <= 11'(start_cnt_q + 11'd1);
			clk_live_q  <= (start_cnt_q == 11'(STARTUP_CYCLES - 1));
		end
	end

	// master clock divider shared by whichever port is master
	logic [4:0] sub_q;
	logic [5:0] bit_q;
	logic       gen_bclk_q;
	logic       gen_lr_q;
	logic       gen_fall;
	logic       gen_rise;
	logic [5:0] nbit;
	logic [5:0] lbit;
	logic       gen_lr_d;
	assign gen_fall = (sub_q == 5'(per - 5'd1));
	assign gen_rise = (sub_q == 5'((per >> 1) - 5'd1));
	assign nbit     = 6'(bit_q + 6'd1) & fmask;
	assign lbit     = m_i2s ? (6'(nbit + 6'd1) & fmask) : nbit;
	assign gen_lr_d = m_tdm ? (nbit == 6'h00)
		: ((lbit < 6'((fmask >> 1) + 6'd1)) ^ m_i2s);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sub_q      <= 5'h00;
			bit_q      <= 6'h00;
			gen_bclk_q <= 1'b0;
			gen_lr_q   <= 1'b0;
		end else if (gen_fall) begin
			sub_q      <= 5'h00;
			bit_q      <= nbit;
			gen_bclk_q <= 1'b0;
			gen_lr_q   <= gen_lr_d;
		end else begin
			sub_q <= 5'(sub_q + 5'd1);
			if (gen_rise)
				gen_bclk_q <= 1'b1;
		end
	end

	// clock pins: driven only by the master port once live
	assign in_clk_o  = '{bclk: gen_bclk_q, lrclk: gen_lr_q};
	assign out_clk_o = '{bclk: gen_bclk_q, lrclk: gen_lr_q};
	assign in_clk_oe = {2{clk_live_q && role.in_m}};
	assign out_clk_oe = {2{clk_live_q && role.out_m}};

	// port-side events: generated or from synchronised pins
	logic in_rise;
	logic in_lr;
	logic in_bit;
	logic out_fall;
	logic out_lr;
	logic chain_bit;
	assign in_rise   = role.in_m ? gen_rise : (s2_q[5] && !s3_q[5]);
	assign in_lr     = role.in_m ? gen_lr_q : s2_q[4];
	assign in_bit    = s2_q[3];
	assign out_fall  = role.out_m ? gen_fall : (!s2_q[2] && s3_q[2]);
	assign out_lr    = role.out_m ? gen_lr_d : s2_q[1];
	assign chain_bit = s2_q[0];

	// input receiver: left-align whatever arrived in the channel
	logic [23:0] acc_q;
	logic [4:0]  n_q;
	logic        in_lr_last_q;
	logic [23:0] left_q;
	logic [23:0] fin_acc;
	logic [4:0]  fin_n;
	logic [4:0]  rjw;
	logic [23:0] aligned;
	always_comb begin
		fin_acc = (ifmt_i2s && n_q != W_24) ? {acc_q[22:0], in_bit} : acc_q;
		fin_n   = (ifmt_i2s && n_q != W_24) ? 5'(n_q + 5'd1) : n_q;
		unique case (input_format_select[1:0])
			2'h0: rjw = W_16;
			2'h1: rjw = W_18;
			2'h2: rjw = W_20;
			default: rjw = W_24;
		endcase
		aligned = fin_acc << (ifmt_rj ? 5'(W_24 - rjw) : 5'(W_24 - fin_n));
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			acc_q         <= 24'h00_0000;
			n_q           <= 5'h00;
			in_lr_last_q  <= 1'b0;
			left_q        <= 24'h00_0000;
			in_pair       <= '0;
			in_pair_valid <= 1'b0;
		end else begin
			in_pair_valid <= 1'b0;
			if (in_rise) begin
				in_lr_last_q <= in_lr;
				if (in_lr != in_lr_last_q) begin
					if (in_lr_last_q ^ ifmt_i2s) begin
						left_q <= aligned;
					end else begin
						in_pair       <= '{left: left_q, right: aligned};
						in_pair_valid <= 1'b1;
					end
					acc_q <= ifmt_i2s ? 24'h00_0000 : {23'h00_0000, in_bit};
					n_q   <= ifmt_i2s ? 5'h00 : 5'h01;
				end else if (ifmt_rj || n_q != W_24) begin
					acc_q <= {acc_q[22:0], in_bit};
					n_q   <= (n_q != W_24) ? 5'(n_q + 5'd1) : n_q;
				end
			end
		end
	end

	// two-entry buffer between sample source and output shifter
	stereo_t src_pair;
	logic    src_valid;
	logic    src_ready;
	stereo_t f_pair;
	logic    f_valid;
	logic    load_ev;
	assign src_pair   = bypass ? in_pair : conv_pair;
	assign src_valid  = bypass ? in_pair_valid : conv_valid;
	assign conv_ready = src_ready && !bypass;

	pair_fifo u_buf (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (src_valid),
		.in_ready  (src_ready),
		.in_data   (src_pair),
		.out_valid (f_valid),
		.out_ready (load_ev),
		.out_data  (f_pair)
	);

	// frame start at an output bit clock fall with the frame edge
	logic out_lr_prev_q;
	logic o_i2s;
	assign o_i2s   = ofmt_i2s && !pack16 ? 1'b1 : ofmt_i2s;
	assign load_ev = out_fall && (out_lr ^ o_i2s) && !(out_lr_prev_q ^ o_i2s);

	// dither source
	logic [15:0] lfsr_q;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			lfsr_q <= LFSR_SEED;
		else
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end

	// frame image for the selected format
	stereo_t     hold_q;
	stereo_t     cur;
	logic [7:0]  ratio_tx;
	logic [7:0]  rx_ratio;
	logic [23:0] l_sh;
	logic [23:0] r_sh;
	logic [63:0] image;
	logic [63:0] shreg_q;
	assign cur      = f_valid ? f_pair : hold_q;
	assign ratio_tx = role.mp_slave ? ratio_used : own_ratio;
	assign l_sh     = shape(cur.left, wout, lfsr_q[7:0], dither_on);
	assign r_sh     = shape(cur.right, wout, lfsr_q[15:8], dither_on);
	always_comb begin
		if (pack16)
			image = {l_sh[23:8], r_sh[23:8], 32'h0000_0000};
		else
			image = {subframe(l_sh, ratio_tx, ofmt_rj, wout),
				subframe(r_sh, ratio_tx, ofmt_rj, wout)};
		if (ofmt_i2s)
			image = image >> 1;
	end
	assign rx_ratio = ofmt_rj ? shreg_q[63:56]
		: (ofmt_i2s ? shreg_q[38:31] : shreg_q[39:32]);

	// output shifter: parallel load at frame start, else chain shift
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			shreg_q       <= 64'h0000_0000_0000_0000;
			out_lr_prev_q <= 1'b0;
			hold_q        <= '0;
		end else if (out_fall) begin
			out_lr_prev_q <= out_lr;
			if (load_ev) begin
				shreg_q <= image;
				hold_q  <= cur;
			end else begin
				shreg_q <= {shreg_q[62:0], chain_bit};
			end
		end
	end
	assign serial_data_out = shreg_q[63];

	// matched-phase ratio taken from the chain at each frame
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			ratio_used <= 8'h00;
		else if (!role.mp_slave)
			ratio_used <= own_ratio;
		else if (load_ev)
			ratio_used <= rx_ratio;
	end

	// data pin released during reset, driven afterwards
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			serial_data_out_oe <= 1'b0;
		else
			serial_data_out_oe <= 1'b1;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_quiet_start;
		!clk_live_q |-> (in_clk_oe == 2'b00) && (out_clk_oe == 2'b00);
	endproperty
	a_quiet_start: assert property (p_quiet_start) else $error("clock pins early");

	property p_live_time;
		$rose(clk_live_q) |-> start_cnt_q == 11'(STARTUP_CYCLES);
	endproperty
	a_live_time: assert property (p_live_time) else $error("startup count wrong");

	property p_one_master;
		!(in_clk_oe.bclk && out_clk_oe.bclk);
	endproperty
	a_one_master: assert property (p_one_master) else $error("two master ports");

	property p_no_dither_bypass;
		bypass |-> !dither_on;
	endproperty
	a_no_dither_bypass: assert property (p_no_dither_bypass) else $error("bypass dither");

	property p_load;
		load_ev |=> shreg_q == $past(image);
	endproperty
	a_load: assert property (p_load) else $error("frame load lost");

	property p_shift;
		(out_fall && !load_ev) |=> shreg_q == {$past(shreg_q[62:0]), $past(chain_bit)};
	endproperty
	a_shift: assert property (p_shift) else $error("chain shift wrong");

	property p_mp_ratio;
		(role.mp_slave && load_ev) ##1 role.mp_slave |-> ratio_used == $past(rx_ratio);
	endproperty
	a_mp_ratio: assert property (p_mp_ratio) else $error("ratio not taken");

	property p_div256;
		(gen_fall && role.mult == 2'h3 && !pack16) ##1 (role.mult == 2'h3 && !pack16)
			|-> !gen_fall ##1 !gen_fall ##1 !gen_fall ##1 gen_fall;
	endproperty
	a_div256: assert property (p_div256) else $error("bit period wrong");

	property p_bypass_path;
		(bypass && in_pair_valid && src_ready) |-> src_valid && src_pair == in_pair;
	endproperty
	a_bypass_path: assert property (p_bypass_path) else $error("bypass path");

	c_tdm_load: cover property (ofmt_tdm && load_ev && f_valid);
	c_bypass_push: cover property (bypass && in_pair_valid);
	c_mp_ratio: cover property (role.mp_slave && load_ev);
	c_buf_full: cover property (!src_ready && !bypass);
endmodule
